// ==== bench/irs_input_route_ctrl_tb_top.sv ====
module irs_input_route_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import irs_pkg::*;
    logic       clk, rstn, reg_wr, reg_rd, reg_rvalid, irq_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [1:0] slicer_above;
    irs_route_t route, route4;
    irs_diag_t  d1, d2;
    int         fails, compares, n;

    // six-input part, fully watched
    irs_input_route_ctrl dut_u (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .route(route),
        .first_diag(d1), .second_diag(d2), .slicer_above(slicer_above),
        .interrupt_request_out_n(irq_n));
    // four-input part shares the stimulus, only its routing is compared
    irs_input_route_ctrl #(.SIX_INPUT(1'b0)) dut4_u (.clk(clk),
        .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(), .reg_rvalid(), .route(route4),
        .first_diag(), .second_diag(), .slicer_above(slicer_above),
        .interrupt_request_out_n());

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // strobes change on the falling edge, taken at the next rising one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(32'(reg_rvalid), 32'h1);
        chk(32'(reg_rdata), 32'(e));
    endtask

    // routing expected for a code; fv 1 cvbs, 2 y/c, 3 comp, 4 diff
    function automatic irs_route_t exp_rt(logic [4:0] c, bit six);
        irs_route_t r;
        logic [2:0] fv, a, b, p;
        {fv, a, b, p} = 12'h000;
        case (c)
            5'h00, 5'h01: {fv, a} = {3'd1, 3'(c + 5'h01)};
            5'h02, 5'h03: {fv, a} = {six ? 3'd1 : 3'd0, 3'(c + 5'h01)};
            5'h06, 5'h07: {fv, a} = {3'd1, 3'(c - (six ? 5'h01 : 5'h03))};
            5'h08: {fv, a, b} = {3'd2, 3'd1, 3'd2};
            5'h09: {fv, a, b} = {six ? 3'd2 : 3'd0, 3'd3, 3'd4};
            5'h0b: {fv, a, b} = six ? 9'o256 : 9'o234;
            5'h0c: {fv, a, b, p} = {six ? 3'd3 : 3'd0, 9'o123};
            5'h0e: {fv, a, b} = {3'd4, 3'd1, 3'd2};
            5'h0f: {fv, a, b} = {six ? 3'd4 : 3'd0, 3'd3, 3'd4};
            5'h11: {fv, a, b} = six ? 9'o456 : 9'o434;
            default: fv = 3'd0;
        endcase
        if (fv == 3'd0)
            {a, b, p} = 9'o000;
        r.fmt = irs_fmt_t'(fv);
        for (int i = 1; i <= 6; i++)
            r.ch_enable[i-1] = (a == i) || (b == i) || (p == i);
        {r.ch_a, r.ch_b, r.ch_c} = {a, b, p};
        r.reserved = (fv == 3'd0);
        return r;
    endfunction

    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog, the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hd8d6));
        {rstn, reg_wr, reg_rd, slicer_above} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk(32'(irq_n), 32'h1);
        chk(32'(d1), 32'hb);
        chk(32'(d2), 32'hb);
        rd(8'h5d, 8'h4c);
        rd(8'h5e, 8'h4c);
        rd(8'h33, 8'h00);
        // every code, reserved ones included, on both variants
        for (int c = 0; c < 32; c++)
        begin
            wr(8'h00, 8'(c));
            rd(8'h00, 8'(c));
            chk(32'(route), 32'(exp_rt(5'(c), 1'b1)));
            chk(32'(route4), 32'(exp_rt(5'(c), 1'b0)));
        end
        // each level, random junk in the bits that must read zero
        for (int i = 0; i < 8; i++)
        begin
            v = (8'($urandom) & 8'ha3) | 8'h40 | 8'(i << 2);
            wr(8'h5d, v);
            wr(8'h5e, v ^ 8'h1c);
            repeat (2) @(negedge clk);
            chk(32'(d1), 32'(8 + i));
            chk(32'(d2), 32'(15 - i));
            rd(8'h5e, (v ^ 8'h1c) & 8'h5c);
        end
        // powered-down pins must not fire
        slicer_above = 2'b11;
        repeat (10) @(negedge clk);
        chk(32'(irq_n), 32'h1);
        slicer_above = 2'b00;
        rd(8'h5f, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            wr(p ? 8'h5e : 8'h5d, 8'h0c);
            slicer_above = 2'(1 << p);
            for (n = 0; n < 9 && irq_n !== 1'b0; n++) @(negedge clk);
            chk(32'(n), 32'h4);
            slicer_above = 2'b00;
            rd(8'h5f, 8'(1 << p));
            repeat (6) @(negedge clk);
            chk(32'(irq_n), 32'h0);
            wr(8'h5f, 8'h03);
            @(negedge clk);
            chk(32'(irq_n), 32'h1);
            rd(8'h5f, 8'h00);
        end
        print_verdict();
    end
endmodule

// ==== bench/irs_route_checker.sv ====
module irs_route_checker
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rstn,
    // register port
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic [7:0]           reg_rdata,
    input wire logic                 reg_rvalid,
    // front end and fault path
    input wire irs_pkg::irs_route_t  route,
    input wire irs_pkg::irs_diag_t   first_diag,
    input wire irs_pkg::irs_diag_t   second_diag,
    input wire logic [1:0]           slicer_above,
    input wire logic                 interrupt_request_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import irs_pkg::*;
    localparam logic [7:0] A1 = IRS_ADDR_FIRST_DIAG_CTRL;
    localparam logic [7:0] A2 = IRS_ADDR_SECOND_DIAG_CTRL;
    localparam logic [7:0] AF = IRS_ADDR_INPUT_FORMAT_SELECT;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // format write, one idle edge, then read of the same place
    sequence s_fmt_wr_rd;
        (reg_wr && reg_addr == AF) ##1 !reg_wr
        ##1 (reg_rd && !reg_wr && reg_addr == AF);
    endsequence
    // clear of both flags with quiet pins around it, so nothing re-sets
    sequence s_quiet_clear;
        (slicer_above == 2'b00)[*2] ##1 (slicer_above == 2'b00 && reg_wr
        && reg_addr == IRS_ADDR_DIAG_STATUS && reg_wdata[1:0] == 2'b11)
        ##1 (slicer_above == 2'b00)[*3];
    endsequence

    a_rd_valid: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_idle: assert property (!reg_rd |=>
        !reg_rvalid && reg_rdata == 8'h00)
        else $error("read data without read");
    a_fmt_readback: assert property (s_fmt_wr_rd |=>
        reg_rdata == {3'h0, $past(reg_wdata[4:0], 3)})
        else $error("format readback wrong");
    a_first_fault_sense_pin_follow: assert property ((reg_wr && reg_addr == A1)
        ##1 !(reg_wr && reg_addr == A1) |=>
        first_diag == {$past(reg_wdata[6], 2), $past(reg_wdata[4:2], 2)})
        else $error("first diag output wrong");
    a_second_fault_sense_pin_follow: assert property ((reg_wr && reg_addr == A2)
        ##1 !(reg_wr && reg_addr == A2) |=>
        second_diag == {$past(reg_wdata[6], 2), $past(reg_wdata[4:2], 2)})
        else $error("second diag output wrong");
    a_reset_out: assert property (disable iff (1'b0) !rstn |=>
        first_diag == 4'hb && second_diag == 4'hb
        && interrupt_request_out_n && route.ch_enable == 6'h00)
        else $error("reset outputs wrong");
    a_cvbs_onehot: assert property (route.fmt == IRS_FMT_CVBS |->
        $onehot(route.ch_enable))
        else $error("composite enables not one channel");
    a_reserved_off: assert property (route.reserved |->
        route.ch_enable == 6'h00 && route.fmt == IRS_FMT_NONE)
        else $error("reserved code powers channels");
    a_irq_clear: assert property (s_quiet_clear |=>
        interrupt_request_out_n)
        else $error("interrupt kept after clear");
endmodule

bind irs_input_route_ctrl irs_route_checker chk_u (.clk(clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .route(route), .first_diag(first_diag), .second_diag(second_diag),
    .slicer_above(slicer_above),
    .interrupt_request_out_n(interrupt_request_out_n));

// ==== common/irs_pkg.sv ====
package irs_pkg;

    // register map (byte-wide registers, user map offsets)
    localparam logic [7:0] IRS_ADDR_INPUT_FORMAT_SELECT = 8'h00;
    localparam logic [7:0] IRS_ADDR_FIRST_DIAG_CTRL     = 8'h5d;
    localparam logic [7:0] IRS_ADDR_SECOND_DIAG_CTRL    = 8'h5e;
    localparam logic [7:0] IRS_ADDR_DIAG_STATUS         = 8'h5f;

    // field positions inside the diag control registers
    localparam int IRS_PWRDN_BIT = 6;
    localparam int IRS_LEVEL_LSB = 2;
    localparam int IRS_LEVEL_MSB = 4;

    // reset values
    localparam logic [4:0] IRS_RST_FORMAT = 5'h00;
    localparam logic       IRS_RST_PWRDN  = 1'b1;
    localparam logic [2:0] IRS_RST_LEVEL  = 3'h3;

    // slice level in millivolts: 75 mV base, 150 mV per step
    localparam int IRS_LEVEL_BASE_MV = 75;
    localparam int IRS_LEVEL_STEP_MV = 150;

    localparam int IRS_NUM_CH  = 6;
    localparam int IRS_NUM_PIN = 2;

    // input format codes
    localparam logic [4:0] IRS_F_CV1  = 5'h00;
    localparam logic [4:0] IRS_F_CV2  = 5'h01;
    localparam logic [4:0] IRS_F_CV3  = 5'h02;
    localparam logic [4:0] IRS_F_CV4  = 5'h03;
    localparam logic [4:0] IRS_F_CV5  = 5'h06;
    localparam logic [4:0] IRS_F_CV6  = 5'h07;
    localparam logic [4:0] IRS_F_YC12 = 5'h08;
    localparam logic [4:0] IRS_F_YC34 = 5'h09;
    localparam logic [4:0] IRS_F_YC56 = 5'h0b;
    localparam logic [4:0] IRS_F_CMP  = 5'h0c;
    localparam logic [4:0] IRS_F_DF12 = 5'h0e;
    localparam logic [4:0] IRS_F_DF34 = 5'h0f;
    localparam logic [4:0] IRS_F_DF56 = 5'h11;

    typedef enum logic [2:0]
    {
        IRS_FMT_NONE,
        IRS_FMT_CVBS,
        IRS_FMT_YC,
        IRS_FMT_COMPONENT,
        IRS_FMT_DIFF
    } irs_fmt_t;

    // routing result handed to the analog front end
    typedef struct packed
    {
        irs_fmt_t                fmt;
        logic [IRS_NUM_CH-1:0]   ch_enable;
        logic [2:0]              ch_a;      // luma / cvbs / positive leg
        logic [2:0]              ch_b;      // chroma / pb / negative leg
        logic [2:0]              ch_c;      // pr
        logic                    reserved;
    } irs_route_t;

    // diag slicer controls for the comparators
    typedef struct packed
    {
        logic       power_down;
        logic [2:0] threshold;
    } irs_diag_t;

endpackage

// ==== src/irs_input_route_ctrl.sv ====
module irs_input_route_ctrl
#(
    parameter bit SIX_INPUT = 1'b1  // 1: six-input variant, 0: four-input
)
(
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rstn,
    // register port
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [7:0]                       reg_addr,
    input  wire logic [7:0]                       reg_wdata,
    output logic      [7:0]                       reg_rdata,
    output logic                                  reg_rvalid,
    // analog front end control
    output irs_pkg::irs_route_t                   route,
    output irs_pkg::irs_diag_t                    first_diag,
    output irs_pkg::irs_diag_t                    second_diag,
    // comparator outputs from the fault-sense pins (asynchronous)
    input  wire logic [irs_pkg::IRS_NUM_PIN-1:0]  slicer_above,
    // interrupt request, active low
    output logic                                  interrupt_request_out_n
);
    import irs_pkg::*;

    logic [4:0]             fmt_sel_q;
    irs_diag_t              diag_q [IRS_NUM_PIN];
    logic [IRS_NUM_PIN-1:0] sync1_q;
    logic [IRS_NUM_PIN-1:0] sync2_q;
    logic [IRS_NUM_PIN-1:0] event_q;
    logic [IRS_NUM_PIN-1:0] event_clr;
    logic [IRS_NUM_PIN-1:0] armed;
    irs_route_t             route_d;

    // one-hot channel enable from a 1-based channel number
    function automatic logic [IRS_NUM_CH-1:0] ch_bit(input logic [2:0] n);
        logic [IRS_NUM_CH-1:0] r;
        r = '0;
        if (n != 3'h0)
        begin
            r[n - 3'h1] = 1'b1;
        end
        return r;
    endfunction

    // build a route entry from format and up to three channels
    function automatic irs_route_t mk(input irs_fmt_t f, input logic [2:0] a,
                                      input logic [2:0] b, input logic [2:0] c);
        irs_route_t r;
        r.fmt       = f;
        r.ch_a      = a;
        r.ch_b      = b;
        r.ch_c      = c;
        r.ch_enable = ch_bit(a) | ch_bit(b) | ch_bit(c);
        r.reserved  = (f == IRS_FMT_NONE);
        return r;
    endfunction

    // format decode; reserved codes leave every channel powered down
    always_comb
    begin
        route_d = mk(IRS_FMT_NONE, 3'h0, 3'h0, 3'h0);
        case (fmt_sel_q)
            IRS_F_CV1:  route_d = mk(IRS_FMT_CVBS, 3'h1, 3'h0, 3'h0);
            IRS_F_CV2:  route_d = mk(IRS_FMT_CVBS, 3'h2, 3'h0, 3'h0);
            IRS_F_CV3:
            begin
                if (SIX_INPUT)
                begin
                    route_d = mk(IRS_FMT_CVBS, 3'h3, 3'h0, 3'h0);
                end
            end
            IRS_F_CV4:
            begin
                if (SIX_INPUT)
                begin
                    route_d = mk(IRS_FMT_CVBS, 3'h4, 3'h0, 3'h0);
                end
            end
            IRS_F_CV5:
            begin
                route_d = SIX_INPUT ? mk(IRS_FMT_CVBS, 3'h5, 3'h0, 3'h0)
                                    : mk(IRS_FMT_CVBS, 3'h3, 3'h0, 3'h0);
            end
            IRS_F_CV6:
            begin
                route_d = SIX_INPUT ? mk(IRS_FMT_CVBS, 3'h6, 3'h0, 3'h0)
                                    : mk(IRS_FMT_CVBS, 3'h4, 3'h0, 3'h0);
            end
            IRS_F_YC12: route_d = mk(IRS_FMT_YC, 3'h1, 3'h2, 3'h0);
            IRS_F_YC34:
            begin
                if (SIX_INPUT)
                begin
                    route_d = mk(IRS_FMT_YC, 3'h3, 3'h4, 3'h0);
                end
            end
            IRS_F_YC56:
            begin
                route_d = SIX_INPUT ? mk(IRS_FMT_YC, 3'h5, 3'h6, 3'h0)
                                    : mk(IRS_FMT_YC, 3'h3, 3'h4, 3'h0);
            end
            IRS_F_CMP:
            begin
                if (SIX_INPUT)
                begin
                    route_d = mk(IRS_FMT_COMPONENT, 3'h1, 3'h2, 3'h3);
                end
            end
            IRS_F_DF12: route_d = mk(IRS_FMT_DIFF, 3'h1, 3'h2, 3'h0);
            IRS_F_DF34:
            begin
                if (SIX_INPUT)
                begin
                    route_d = mk(IRS_FMT_DIFF, 3'h3, 3'h4, 3'h0);
                end
            end
            IRS_F_DF56:
            begin
                route_d = SIX_INPUT ? mk(IRS_FMT_DIFF, 3'h5, 3'h6, 3'h0)
                                    : mk(IRS_FMT_DIFF, 3'h3, 3'h4, 3'h0);
            end
            default:    route_d = mk(IRS_FMT_NONE, 3'h0, 3'h0, 3'h0);
        endcase
    end

    // route registered so the analog side sees glitch-free enables
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            route <= mk(IRS_FMT_NONE, 3'h0, 3'h0, 3'h0);
        end
        else
        begin
            route <= route_d;
        end
    end

    // format select register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            fmt_sel_q <= IRS_RST_FORMAT;
        end
        else if (reg_wr && reg_addr == IRS_ADDR_INPUT_FORMAT_SELECT)
        begin
            fmt_sel_q <= reg_wdata[4:0];
        end
    end

    // diag slicer control registers, powered down after reset
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < IRS_NUM_PIN; i++)
            begin
                diag_q[i].power_down <= IRS_RST_PWRDN;
                diag_q[i].threshold  <= IRS_RST_LEVEL;
            end
        end
        else if (reg_wr)
        begin
            if (reg_addr == IRS_ADDR_FIRST_DIAG_CTRL)
            begin
                diag_q[0].power_down <= reg_wdata[IRS_PWRDN_BIT];
                diag_q[0].threshold  <=
                    reg_wdata[IRS_LEVEL_MSB:IRS_LEVEL_LSB];
            end
            if (reg_addr == IRS_ADDR_SECOND_DIAG_CTRL)
            begin
                diag_q[1].power_down <= reg_wdata[IRS_PWRDN_BIT];
                diag_q[1].threshold  <=
                    reg_wdata[IRS_LEVEL_MSB:IRS_LEVEL_LSB];
            end
        end
    end

    // controls out to the comparators
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            first_diag  <= '{IRS_RST_PWRDN, IRS_RST_LEVEL};
            second_diag <= '{IRS_RST_PWRDN, IRS_RST_LEVEL};
        end
        else
        begin
            first_diag  <= diag_q[0];
            second_diag <= diag_q[1];
        end
    end

    // comparator outputs cross in through two flops
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= slicer_above;
            sync2_q <= sync1_q;
        end
    end

    // status clear: write one to the pin's bit in the status register
    assign event_clr = (reg_wr && reg_addr == IRS_ADDR_DIAG_STATUS)
                       ? reg_wdata[IRS_NUM_PIN-1:0] : '0;

    // a powered-down slicer output is ignored, it may float
    generate
        for (genvar p = 0; p < IRS_NUM_PIN; p++)
        begin : g_pin
            assign armed[p] = !diag_q[p].power_down;

            // sticky flag; set beats a simultaneous clear
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    event_q[p] <= 1'b0;
                end
                else if (armed[p] && sync2_q[p])
                begin
                    event_q[p] <= 1'b1;
                end
                else if (event_clr[p])
                begin
                    event_q[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt follows the flags, registered, active low
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            interrupt_request_out_n <= 1'b1;
        end
        else
        begin
            interrupt_request_out_n <= ~(|event_q);
        end
    end

    // register readback, one cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            reg_rdata  <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    IRS_ADDR_INPUT_FORMAT_SELECT:
                        reg_rdata <= {3'h0, fmt_sel_q};
                    IRS_ADDR_FIRST_DIAG_CTRL:
                        reg_rdata <= {1'b0, diag_q[0].power_down, 1'b0,
                                      diag_q[0].threshold, 2'h0};
                    IRS_ADDR_SECOND_DIAG_CTRL:
                        reg_rdata <= {1'b0, diag_q[1].power_down, 1'b0,
                                      diag_q[1].threshold, 2'h0};
                    IRS_ADDR_DIAG_STATUS:
                        reg_rdata <= {6'h00, event_q};
                    default:
                        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule
